//--- core/nft_defines.vh
// nft_defines.vh: command codes, pin timing counts and busy limits for the
// nand flash host sequencer. assumes a 25 MHz system clock.
`ifndef NFT_DEFINES_VH
`define NFT_DEFINES_VH

`define NFT_CLK_PERIOD_NS       40

// command codes
`define NFT_CMD_READ1           8'h00
`define NFT_CMD_READ2           8'h30
`define NFT_CMD_CACHE_READ      8'h31
`define NFT_CMD_CACHE_LAST      8'h3f
`define NFT_CMD_COPY_READ       8'h3a
`define NFT_CMD_DATA_IN         8'h80
`define NFT_CMD_PROG            8'h10
`define NFT_CMD_PROG_11         8'h11
`define NFT_CMD_PROG_CACHE      8'h15
`define NFT_CMD_ERASE1          8'h60
`define NFT_CMD_ERASE2          8'hd0
`define NFT_CMD_STATUS          8'h70
`define NFT_CMD_RESET           8'hff

// status bit that shows ready
`define NFT_STAT_READY_BIT      6

// pin timing, ns as printed
`define NFT_WHR_NS              60
`define NFT_WB_NS               100
`define NFT_RHW_NS              30
`define NFT_WHR_CYC             ((`NFT_WHR_NS + `NFT_CLK_PERIOD_NS - 1) / `NFT_CLK_PERIOD_NS)
`define NFT_WB_CYC              ((`NFT_WB_NS + `NFT_CLK_PERIOD_NS - 1) / `NFT_CLK_PERIOD_NS)
`define NFT_RHW_CYC             ((`NFT_RHW_NS + `NFT_CLK_PERIOD_NS - 1) / `NFT_CLK_PERIOD_NS)

// busy limits, us as printed
`define NFT_WCB_SHORT_US        10
`define NFT_WCB_LONG_US         700
`define NFT_A2B_US              25
`define NFT_RCB_US              25
`define NFT_CCB_US              30
`define NFT_PROG_US             700
`define NFT_ERASE_US            5000
`define NFT_RST_ERASE_US        500
`define NFT_US_CYC(us)          ((us) * 1000 / `NFT_CLK_PERIOD_NS)

// partial program limit per page
`define NFT_MAX_PARTIAL         4

// operation codes on the command port
`define NFT_OP_READ             3'h0
`define NFT_OP_CACHE_READ       3'h1
`define NFT_OP_CACHE_LAST       3'h2
`define NFT_OP_PROG             3'h3
`define NFT_OP_PROG_CACHE       3'h4
`define NFT_OP_ERASE            3'h5
`define NFT_OP_RESET            3'h6
`define NFT_OP_COPY_READ        3'h7

`endif

//--- core/nft_pcount.v
// nft_pcount.v: per-page partial program counters in a small memory.
// assumes one access per cycle; read data registered.
`timescale 1ns/100ps
module nft_pcount (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // access
   input  wire [5:0] addr,
   input  wire       we,
   input  wire [2:0] wdata,
   input  wire       clr_all,
   output reg  [2:0] rdata
);
   reg  [2:0] mem [0:63];
   integer    i;

   // counter store, cleared on block erase or reset
   always @(posedge clk) begin
      if (!nrst || clr_all) begin
         for (i = 0; i < 64; i = i + 1)
            mem[i] <= 3'h0;
         rdata <= 3'h0;
      end else begin
         if (we)
            mem[addr] <= wdata;
         rdata <= mem[addr];
      end
   end
endmodule

//--- core/nft_host.v
// nft_host.v: host sequencer for an asynchronous x8 nand flash.
// assumes the flash pins are sampled synchronously and RB has a pull-up.
`timescale 1ns/100ps
`include "nft_defines.vh"

module nft_host #(
   parameter ERASE_CYC = `NFT_US_CYC(`NFT_ERASE_US),
   parameter WLONG_CYC = `NFT_US_CYC(`NFT_WCB_LONG_US)
) (
   // clock and reset
   input  wire        SYS_CLK,
   input  wire        NRST,
   // command port
   input  wire        OP_VALID,
   output wire        OP_READY,
   input  wire [2:0]  OP_CODE,
   input  wire [39:0] OP_ADDR,
   input  wire        OP_LAST,
   output reg         OP_DONE,
   output reg         OP_ERROR,
   // data port
   input  wire [7:0]  WR_DATA,
   input  wire        WR_VALID,
   output wire        WR_READY,
   output reg  [7:0]  RD_DATA,
   output reg         RD_VALID,
   input  wire [12:0] XFER_LEN,
   // flash pins
   output reg         CE_N,
   output reg         CLE,
   output reg         ALE,
   output reg         WE_N,
   output reg         READ_STROBE_N,
   output reg         WP_N,
   input  wire        READY_BUSY_N,
   input  wire [7:0]  IO_I,
   output reg  [7:0]  IO_O,
   output reg         IO_OE
);
   localparam S_IDLE = 4'h0, S_CMD1 = 4'h1, S_ADDR = 4'h2, S_WDAT = 4'h3;
   localparam S_CMD2 = 4'h4, S_WB = 4'h5, S_BUSY = 4'h6, S_RDAT = 4'h7;
   localparam S_STAT = 4'h8, S_SREAD = 4'h9, S_RST = 4'ha, S_DONE = 4'hb;

   // timing limits in cycles, sized to the timer
   localparam [23:0] A2B_LIM   = `NFT_US_CYC(`NFT_A2B_US);
   localparam [23:0] RCB_LIM   = `NFT_US_CYC(`NFT_RCB_US);
   localparam [23:0] CCB_LIM   = `NFT_US_CYC(`NFT_CCB_US);
   localparam [23:0] PROG_LIM  = `NFT_US_CYC(`NFT_PROG_US);
   localparam [23:0] PROG2_LIM = 2 * `NFT_US_CYC(`NFT_PROG_US);
   localparam [23:0] RSTB_LIM  = `NFT_US_CYC(`NFT_RST_ERASE_US);
   localparam [23:0] WB_LIM    = `NFT_WB_CYC;
   localparam [23:0] SRD_LO    = `NFT_WHR_CYC;
   localparam [23:0] SRD_HI    = `NFT_WHR_CYC + 2;
   localparam [23:0] RHW_LIM   = `NFT_WHR_CYC + 2 + `NFT_RHW_CYC;
   localparam [2:0]  MAX_PART  = `NFT_MAX_PARTIAL;

   reg  [3:0]  st_q;
   reg  [2:0]  op_q;
   reg  [39:0] addr_q;
   reg  [2:0]  ncyc_q;
   reg  [1:0]  ph_q;
   reg  [12:0] cnt_q;
   reg  [23:0] tmr_q;
   reg  [23:0] lim_q;
   reg         last_q;
   reg         cread_q;
   reg         cprog_q;
   reg         need_rst_q;
   reg         erase_act_q;
   reg  [5:0]  pg_q;
   reg         pc_we;
   reg  [2:0]  pc_wdata;
   wire [2:0]  pc_rdata;

   // busy limit for an operation, cycles
   function [23:0] busy_lim;
      input [2:0] op;
      input       last;
      begin
         case (op)
            `NFT_OP_READ:       busy_lim = A2B_LIM;
            `NFT_OP_CACHE_READ: busy_lim = RCB_LIM;
            `NFT_OP_CACHE_LAST: busy_lim = RCB_LIM;
            `NFT_OP_COPY_READ:  busy_lim = CCB_LIM;
            `NFT_OP_PROG_CACHE: busy_lim = last ? PROG2_LIM
                                                : WLONG_CYC[23:0];
            `NFT_OP_ERASE:      busy_lim = ERASE_CYC[23:0];
            `NFT_OP_RESET:      busy_lim = RSTB_LIM;
            default:            busy_lim = PROG_LIM;
         endcase
      end
   endfunction

   // first and second command for an operation
   function [7:0] cmd1;
      input [2:0] op;
      begin
         case (op)
            `NFT_OP_READ:       cmd1 = `NFT_CMD_READ1;
            `NFT_OP_CACHE_READ: cmd1 = `NFT_CMD_CACHE_READ;
            `NFT_OP_CACHE_LAST: cmd1 = `NFT_CMD_CACHE_LAST;
            `NFT_OP_COPY_READ:  cmd1 = `NFT_CMD_READ1;
            `NFT_OP_ERASE:      cmd1 = `NFT_CMD_ERASE1;
            `NFT_OP_RESET:      cmd1 = `NFT_CMD_RESET;
            default:            cmd1 = `NFT_CMD_DATA_IN;
         endcase
      end
   endfunction

   function [7:0] cmd2;
      input [2:0] op;
      input       last;
      begin
         case (op)
            `NFT_OP_READ:       cmd2 = `NFT_CMD_READ2;
            `NFT_OP_COPY_READ:  cmd2 = `NFT_CMD_COPY_READ;
            `NFT_OP_ERASE:      cmd2 = `NFT_CMD_ERASE2;
            `NFT_OP_PROG_CACHE: cmd2 = last ? `NFT_CMD_PROG
                                            : `NFT_CMD_PROG_CACHE;
            default:            cmd2 = `NFT_CMD_PROG;
         endcase
      end
   endfunction

   assign OP_READY = (st_q == S_IDLE) && !need_rst_q;
   assign WR_READY = (st_q == S_WDAT) && (ph_q == 2'h0);

   wire single_cmd = (op_q == `NFT_OP_CACHE_READ) || (op_q == `NFT_OP_CACHE_LAST)
                     || (op_q == `NFT_OP_RESET);
   wire is_prog    = (op_q == `NFT_OP_PROG) || (op_q == `NFT_OP_PROG_CACHE);
   wire has_rdat   = (op_q == `NFT_OP_READ) || (op_q == `NFT_OP_CACHE_READ)
                     || (op_q == `NFT_OP_CACHE_LAST);

   nft_pcount u_pcount (
      .clk     (SYS_CLK),
      .nrst    (NRST),
      .addr    (pg_q),
      .we      (pc_we),
      .wdata   (pc_wdata),
      .clr_all (erase_act_q),
      .rdata   (pc_rdata)
   );

   // main sequencer: each write cycle takes two phases, strobe low then high; a read data cycle takes three
   always @(posedge SYS_CLK) begin
      if (!NRST) begin
         st_q <= S_IDLE; op_q <= 3'h0; addr_q <= 40'h0; ncyc_q <= 3'h0;
         ph_q <= 2'h0; cnt_q <= 13'h0; tmr_q <= 24'h0; lim_q <= 24'h0;
         last_q <= 1'b0; cread_q <= 1'b0; cprog_q <= 1'b0; need_rst_q <= 1'b0;
         erase_act_q <= 1'b0; pc_we <= 1'b0; pc_wdata <= 3'h0; pg_q <= 6'h00;
         OP_DONE <= 1'b0; OP_ERROR <= 1'b0; RD_DATA <= 8'h00; RD_VALID <= 1'b0;
         CE_N <= 1'b1; CLE <= 1'b0; ALE <= 1'b0; WE_N <= 1'b1;
         READ_STROBE_N <= 1'b1; WP_N <= 1'b0; IO_O <= 8'h00; IO_OE <= 1'b0;
      end else begin
         OP_DONE <= 1'b0; OP_ERROR <= 1'b0; RD_VALID <= 1'b0;
         pc_we <= 1'b0; erase_act_q <= 1'b0;
         case (st_q)
            S_IDLE: begin
               CE_N <= 1'b1; CLE <= 1'b0; ALE <= 1'b0; IO_OE <= 1'b0;
               WP_N <= 1'b1;
               if (need_rst_q && READY_BUSY_N) begin
                  op_q <= `NFT_OP_RESET; st_q <= S_CMD1; ph_q <= 2'h0;
               end else if (OP_VALID && !need_rst_q) begin
                  // cached read only after a page read; last page ends it
                  if ((OP_CODE == `NFT_OP_CACHE_READ || OP_CODE == `NFT_OP_CACHE_LAST)
                      && !cread_q) begin
                     // refusal still passes through done so ready drops
                     OP_ERROR <= 1'b1; st_q <= S_DONE;
                  end else begin
                     op_q <= OP_CODE; addr_q <= OP_ADDR; last_q <= OP_LAST;
                     pg_q <= OP_ADDR[21:16];
                     st_q <= S_CMD1; ph_q <= 2'h0;
                  end
               end
            end
            S_CMD1, S_CMD2: begin
               CE_N <= 1'b0; CLE <= 1'b1; ALE <= 1'b0; IO_OE <= 1'b1;
               IO_O <= (st_q == S_CMD1) ? cmd1(op_q) : cmd2(op_q, last_q);
               if (ph_q == 2'h0) begin
                  WE_N <= 1'b0; ph_q <= 2'h1;
               end else begin
                  WE_N <= 1'b1; ph_q <= 2'h0; cnt_q <= 13'h0;
                  if (st_q == S_CMD2 || single_cmd) begin
                     st_q <= S_WB; tmr_q <= 24'h0;
                     lim_q <= busy_lim(op_q, last_q);
                  end else begin
                     st_q <= S_ADDR;
                     ncyc_q <= (op_q == `NFT_OP_ERASE) ? 3'h3 : 3'h5;
                  end
               end
            end
            S_ADDR: begin
               CLE <= 1'b0; ALE <= 1'b1; IO_OE <= 1'b1;
               IO_O <= (op_q == `NFT_OP_ERASE) ? addr_q[23:16] : addr_q[7:0];
               if (ph_q == 2'h0) begin
                  WE_N <= 1'b0; ph_q <= 2'h1;
               end else begin
                  WE_N <= 1'b1; ph_q <= 2'h0;
                  addr_q <= (op_q == `NFT_OP_ERASE) ? {addr_q[39:24], addr_q[15:0], addr_q[23:16]}
                                                    : {addr_q[7:0], addr_q[39:8]};
                  ncyc_q <= ncyc_q - 3'h1;
                  if (ncyc_q == 3'h1) begin
                     // rotation restores the original order on the last cycle
                     if (is_prog) begin
                        if (pc_rdata >= MAX_PART) begin
                           OP_ERROR <= 1'b1; st_q <= S_DONE;
                        end else begin
                           st_q <= S_WDAT; pc_we <= 1'b1;
                           pc_wdata <= pc_rdata + 3'h1;
                        end
                     end else
                        st_q <= S_CMD2;
                  end
               end
            end
            S_WDAT: begin
               ALE <= 1'b0; IO_OE <= 1'b1;
               if (ph_q == 2'h0) begin
                  if (WR_VALID) begin
                     IO_O <= WR_DATA; WE_N <= 1'b0; ph_q <= 2'h1;
                  end
               end else begin
                  WE_N <= 1'b1; ph_q <= 2'h0; cnt_q <= cnt_q + 13'h1;
                  if (cnt_q + 13'h1 == XFER_LEN)
                     st_q <= S_CMD2;
               end
            end
            S_WB: begin
               // wait out the write-to-busy window before sampling ready
               CLE <= 1'b0; IO_OE <= 1'b0; tmr_q <= tmr_q + 24'h1;
               if (tmr_q >= WB_LIM) begin
                  st_q <= S_BUSY; tmr_q <= 24'h0;
               end
            end
            S_BUSY: begin
               tmr_q <= tmr_q + 24'h1;
               if (READY_BUSY_N) begin
                  if (op_q == `NFT_OP_ERASE) erase_act_q <= 1'b1;
                  if (op_q == `NFT_OP_RESET) begin
                     need_rst_q <= 1'b0; erase_act_q <= 1'b1;
                  end
                  cread_q <= (op_q == `NFT_OP_READ) ? 1'b1 :
                             (op_q == `NFT_OP_CACHE_READ) ? 1'b1 :
                             (op_q == `NFT_OP_CACHE_LAST) ? 1'b0 : cread_q;
                  if (op_q == `NFT_OP_PROG_CACHE)
                     cprog_q <= !last_q;
                  cnt_q <= 13'h0; ph_q <= 2'h0; tmr_q <= 24'h0;
                  if (has_rdat)
                     st_q <= S_RDAT;
                  else if (op_q == `NFT_OP_PROG_CACHE && last_q)
                     st_q <= S_STAT;
                  else
                     st_q <= S_DONE;
               end else if (tmr_q >= lim_q) begin
                  OP_ERROR <= 1'b1; st_q <= S_DONE;
                  if (op_q == `NFT_OP_PROG_CACHE) need_rst_q <= 1'b1;
               end
            end
            S_RDAT: begin
               // strobe held low two cycles; data sampled in the cycle it rises
               IO_OE <= 1'b0;
               if (ph_q == 2'h0) begin
                  READ_STROBE_N <= 1'b0; ph_q <= 2'h1;
               end else if (ph_q == 2'h1) begin
                  ph_q <= 2'h2;
               end else begin
                  RD_DATA <= IO_I; RD_VALID <= 1'b1;
                  READ_STROBE_N <= 1'b1; ph_q <= 2'h0; cnt_q <= cnt_q + 13'h1;
                  if (cnt_q + 13'h1 == XFER_LEN)
                     st_q <= S_DONE;
               end
            end
            S_STAT: begin
               CE_N <= 1'b0; CLE <= 1'b1; IO_OE <= 1'b1; IO_O <= `NFT_CMD_STATUS;
               if (ph_q == 2'h0) begin
                  WE_N <= 1'b0; ph_q <= 2'h1;
               end else begin
                  WE_N <= 1'b1; ph_q <= 2'h0; st_q <= S_SREAD; tmr_q <= 24'h0;
               end
            end
            S_SREAD: begin
               CLE <= 1'b0; IO_OE <= 1'b0; tmr_q <= tmr_q + 24'h1;
               if (tmr_q == SRD_LO)
                  READ_STROBE_N <= 1'b0;
               else if (tmr_q == SRD_HI) begin
                  READ_STROBE_N <= 1'b1;
                  if (IO_I[`NFT_STAT_READY_BIT]) begin
                     need_rst_q <= 1'b1; st_q <= S_RST;
                  end else begin
                     st_q <= S_STAT; ph_q <= 2'h0;
                  end
               end
            end
            S_RST: begin
               // hold off the write strobe after the read strobe rises
               tmr_q <= tmr_q + 24'h1;
               if (tmr_q >= RHW_LIM)
                  st_q <= S_DONE;
            end
            S_DONE: begin
               CE_N <= 1'b1; OP_DONE <= 1'b1; st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end
endmodule

//--- dv/nft_host_sva.sv
// nft_host_sva.sv: pin and handshake checks on the nand host sequencer.
// assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/100ps
module nft_host_sva (
   // clock and reset
   input wire       SYS_CLK,
   input wire       NRST,
   // command port
   input wire       OP_VALID,
   input wire       OP_READY,
   input wire       OP_DONE,
   input wire       OP_ERROR,
   // flash pins
   input wire       CE_N,
   input wire       CLE,
   input wire       ALE,
   input wire       WE_N,
   input wire       READ_STROBE_N,
   input wire       WP_N,
   input wire [7:0] IO_O,
   input wire       IO_OE
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);
   // parked pins, latches and strobes
   chk_rst_park: assert property (NRST && !$past(NRST) |-> CE_N && WE_N && !IO_OE)
      else $error("pins not parked after reset");
   chk_latch_excl: assert property (!(CLE && ALE))
      else $error("command and address latch both high");
   chk_we_pulse: assert property (!WE_N |=> WE_N)
      else $error("write strobe low longer than one cycle");
   chk_sel_strobe: assert property (!WE_N || !READ_STROBE_N |-> !CE_N)
      else $error("strobe while chip not selected");
   chk_strobe_len: assert property ($fell(READ_STROBE_N) |-> !READ_STROBE_N[*2] ##1 READ_STROBE_N)
      else $error("read strobe low time wrong");
   chk_read_hiz: assert property (!READ_STROBE_N |-> !IO_OE)
      else $error("host drives bus during read");
   chk_cmd_drive: assert property (CLE && !WE_N |-> IO_OE && WP_N)
      else $error("command written without bus drive");
   chk_taken_busy: assert property (OP_VALID && OP_READY |=> !OP_READY)
      else $error("ready stays high after request taken");
   chk_done_pulse: assert property (OP_DONE |=> !OP_DONE)
      else $error("done longer than one cycle");
   chk_err_pulse: assert property (OP_ERROR |=> !OP_ERROR)
      else $error("error longer than one cycle");
   // main scenarios reached
   cov_err: cover property (OP_ERROR ##1 OP_DONE);
   cov_reset_cmd: cover property (CLE && !WE_N && IO_O == 8'hff);
   cov_cache_cmd: cover property (CLE && !WE_N && IO_O == 8'h15);
endmodule

bind nft_host nft_host_sva u_sva (.SYS_CLK(SYS_CLK), .NRST(NRST), .OP_VALID(OP_VALID),
   .OP_READY(OP_READY), .OP_DONE(OP_DONE), .OP_ERROR(OP_ERROR), .CE_N(CE_N), .CLE(CLE),
   .ALE(ALE), .WE_N(WE_N), .READ_STROBE_N(READ_STROBE_N), .WP_N(WP_N), .IO_O(IO_O),
   .IO_OE(IO_OE));

//--- dv/nft_flash_model.sv
// nft_flash_model.sv: behavioural x8 nand flash with one small page store.
// assumes pins sampled on the host clock; busy length set by the bench.
`timescale 1ns/100ps
module nft_flash_model (
   // clock and busy length
   input  wire        clk,
   input  wire [11:0] busy_len,
   // flash pins
   input  wire        ce_n,
   input  wire        cle,
   input  wire        ale,
   input  wire        we_n,
   input  wire        read_strobe_n,
   input  wire [7:0]  io_o,
   output wire        ready_busy_n,
   output wire [7:0]  io_i
);
   reg [7:0]   mem [0:15];
   reg [3:0]   widx_q;
   reg [3:0]   ridx_q;
   reg [11:0]  busy_q;
   reg         stat_q;
   reg         strobe_q;
   reg [7:0]   last_q;
   reg [7:0]   last_cmd;
   reg [255:0] seen;
   wire [7:0]  dout;
   integer     i;
   // status shows ready on bit six
   assign dout = stat_q ? {1'b0, busy_q == 12'h0, 6'h00} : mem[ridx_q];
   assign ready_busy_n = (busy_q == 12'h0);
   // released bus shows the inverse of the last byte
   assign io_i = (!ce_n && !read_strobe_n) ? dout : ~last_q;
   // erased page, idle device
   initial begin
      for (i = 0; i < 16; i = i + 1) mem[i] = 8'hff;
      {widx_q, ridx_q, busy_q, stat_q, last_q, last_cmd, seen} = 0;
      strobe_q = 1'b1;
   end
   // command, address and data capture, busy timing
   always @(posedge clk) begin
      strobe_q <= read_strobe_n;
      if (busy_q != 12'h0) busy_q <= busy_q - 12'h001;
      if (read_strobe_n && !strobe_q && !stat_q) ridx_q <= ridx_q + 4'h1;
      if (!ce_n && !read_strobe_n) last_q <= dout;
      if (!ce_n && !we_n) begin
         if (cle) begin
            last_cmd <= io_o;
            seen[io_o] <= 1'b1;
            stat_q <= (io_o == 8'h70);
            ridx_q <= 4'h0;
            case (io_o)
               8'h30, 8'h31, 8'h3f, 8'h3a, 8'h10, 8'h11, 8'h15, 8'hd0, 8'hff:
                  busy_q <= busy_len;
               default: ;
            endcase
         end else if (ale) begin
            widx_q <= 4'h0;
            ridx_q <= 4'h0;
         end else begin
            mem[widx_q] <= io_o;
            widx_q <= widx_q + 4'h1;
         end
      end
   end
endmodule

//--- dv/tb_top.sv
// tb_top.sv: self-checking bench for the nand host sequencer.
// assumes the flash model answers on the far side; shortened erase count.
`timescale 1ns/100ps
`include "nft_defines.vh"
module tb_top;
   reg sys_clk, nrst, op_valid, op_last, wr_valid, got_err, got_done;
   reg [2:0] op_code;
   reg [39:0] op_addr;
   reg [7:0] wr_data, w0;
   reg [12:0] xfer_len;
   reg [11:0] busy_len;
   reg [7:0] rd_buf [0:15];
   integer rd_n, n_fail, total_checks, i;
   wire op_ready, op_done, op_error, wr_ready, rd_valid, ce_n, cle, ale, we_n, rs_n, rb_n;
   wire [7:0] rd_data, io_i, io_o;
   nft_host #(.ERASE_CYC(50), .WLONG_CYC(50)) dut (.SYS_CLK(sys_clk), .NRST(nrst),
      .OP_VALID(op_valid), .OP_READY(op_ready), .OP_CODE(op_code), .OP_ADDR(op_addr),
      .OP_LAST(op_last), .OP_DONE(op_done), .OP_ERROR(op_error), .WR_DATA(wr_data),
      .WR_VALID(wr_valid), .WR_READY(wr_ready), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .XFER_LEN(xfer_len), .CE_N(ce_n), .CLE(cle), .ALE(ale), .WE_N(we_n),
      .READ_STROBE_N(rs_n), .WP_N(), .READY_BUSY_N(rb_n), .IO_I(io_i), .IO_O(io_o),
      .IO_OE());
   nft_flash_model u_flash (.clk(sys_clk), .busy_len(busy_len), .ce_n(ce_n), .cle(cle),
      .ale(ale), .we_n(we_n), .read_strobe_n(rs_n), .io_o(io_o), .ready_busy_n(rb_n),
      .io_i(io_i));
   // 25 mhz clock
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // write stream and read capture
   always @(posedge sys_clk) begin
      if (wr_valid && wr_ready) wr_data <= wr_data + 8'h01;
      if (rd_valid === 1'b1) begin
         rd_buf[rd_n % 16] <= rd_data;
         rd_n <= rd_n + 1;
      end
   end
   task check(input ok, input [8*24-1:0] what);
      begin
         total_checks = total_checks + 1;
         if (ok !== 1'b1) begin
            n_fail = n_fail + 1;
            $display("wrong value at %0t: %0s", $time, what);
         end
      end
   endtask
   task final_report;
      begin
         $display("checks %0d, mismatches %0d", total_checks, n_fail);
         if (n_fail == 0 && total_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   task wait_ready;
      integer k;
      begin
         k = 0;
         while (op_ready !== 1'b1 && k < 5000) begin
            @(posedge sys_clk);
            k = k + 1;
         end
      end
   endtask
   // one operation: handshake in, wait for done, gather error
   task run_op(input [2:0] c, input [39:0] a, input l, input [12:0] n);
      integer k;
      begin
         op_code <= c;
         op_addr <= a;
         op_last <= l;
         xfer_len <= n;
         op_valid <= 1'b1;
         rd_n <= 0;
         @(posedge sys_clk);
         wait_ready;
         op_valid <= 1'b0;
         {got_err, got_done} = 2'b00;
         k = 0;
         while (!got_done && k < 20000) begin
            @(posedge sys_clk);
            got_done = (op_done === 1'b1);
            got_err = got_err | (op_error === 1'b1);
            k = k + 1;
         end
         check(got_done, "operation never done");
      end
   endtask
   task t_early_cache;
      begin
         run_op(`NFT_OP_CACHE_READ, 40'h0, 1'b0, 13'd4);
         check(got_err, "cache read not refused");
         $display("test early_cache done");
      end
   endtask
   task t_prog_read;
      begin
         w0 = wr_data;
         run_op(`NFT_OP_PROG, 40'h0000010000, 1'b0, 13'd8);
         check(!got_err, "program failed");
         run_op(`NFT_OP_READ, 40'h0000010000, 1'b0, 13'd8);
         check(!got_err && rd_n == 8, "read count");
         for (i = 0; i < 8; i = i + 1) check(rd_buf[i] === w0 + i[7:0], "read data");
         $display("test prog_read done");
      end
   endtask
   task t_cache_read;
      begin
         run_op(`NFT_OP_CACHE_READ, 40'h0, 1'b0, 13'd8);
         check(!got_err && rd_n == 8, "cache read");
         run_op(`NFT_OP_CACHE_LAST, 40'h0, 1'b0, 13'd8);
         check(!got_err && rd_n == 8, "cache last read");
         check(u_flash.seen[8'h31] && u_flash.seen[8'h3f], "cache commands");
         $display("test cache_read done");
      end
   endtask
   task t_partial;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            run_op(`NFT_OP_PROG, 40'h0000050000, 1'b0, 13'd4);
            check(!got_err, "partial refused early");
         end
         run_op(`NFT_OP_PROG, 40'h0000050000, 1'b0, 13'd4);
         check(got_err, "fifth partial taken");
         run_op(`NFT_OP_ERASE, 40'h0000050000, 1'b0, 13'd0);
         check(!got_err, "erase failed");
         run_op(`NFT_OP_PROG, 40'h0000050000, 1'b0, 13'd4);
         check(!got_err, "count not cleared");
         $display("test partial done");
      end
   endtask
   task t_cache_prog;
      begin
         run_op(`NFT_OP_PROG_CACHE, 40'h0000020000, 1'b0, 13'd4);
         check(!got_err, "cache page failed");
         run_op(`NFT_OP_PROG_CACHE, 40'h0000030000, 1'b1, 13'd4);
         check(!got_err, "final page failed");
         wait_ready;
         check(u_flash.seen[8'h15] && u_flash.seen[8'h10], "confirm codes");
         check(u_flash.seen[8'h70], "no status poll");
         check(u_flash.last_cmd === 8'hff, "no closing reset");
         $display("test cache_prog done");
      end
   endtask
   task t_copy_erase_reset;
      begin
         run_op(`NFT_OP_COPY_READ, 40'h0000010000, 1'b0, 13'd4);
         check(!got_err && u_flash.seen[8'h3a], "copy read");
         busy_len <= 12'd200;
         run_op(`NFT_OP_ERASE, 40'h0000010000, 1'b0, 13'd0);
         check(got_err, "slow erase not flagged");
         busy_len <= 12'd20;
         run_op(`NFT_OP_RESET, 40'h0, 1'b0, 13'd0);
         check(!got_err && u_flash.last_cmd === 8'hff, "reset");
         $display("test copy_erase_reset done");
      end
   endtask
   // watchdog
   initial begin
      repeat (60000) @(posedge sys_clk);
      n_fail = n_fail + 1;
      $display("wrong value at %0t: watchdog expired", $time);
      final_report;
   end
   // main sequence
   initial begin
      {nrst, op_valid, op_last, op_code, op_addr, xfer_len} = 0;
      {wr_valid, wr_data, busy_len} = {1'b1, 8'h10, 12'd20};
      {rd_n, n_fail, total_checks} = 0;
      repeat (2) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      t_early_cache;
      t_prog_read;
      t_cache_read;
      t_partial;
      t_cache_prog;
      t_copy_erase_reset;
      final_report;
   end
endmodule
